// [src/bed_pkg.sv]
// bed_pkg: constants, enums, structs and APB map of the error checker.
// assumes a 40 MHz pclk; the bit clock arrives as a strobe in that domain.
package bed_pkg;
  localparam int          CLK_HZ        = 40000000;
  localparam int          SECOND_NS     = 1000000000;
  localparam int          CLK_NS        = SECOND_NS / CLK_HZ;
  localparam int          TICK_CYCLES   = SECOND_NS / CLK_NS;
  localparam logic [31:0] GATE_MIN_S    = 32'h0000_0001;
  localparam logic [31:0] GATE_MAX_S    = 32'h000d_2f00 - 32'h1;
  localparam int          FRAME_BITS    = 64;
  localparam int          FRAME_MIN_LEN = 128;
  localparam int          UPAT_AW       = 12;
  localparam int          UPAT_DEPTH    = 4096;
  localparam int          THR_MIN_DEC   = 2;
  localparam int          THR_MAX_DEC   = 8;
  localparam int          SYNC_WIN_LOG  = 10;
  localparam int          IDLE_LOG      = 10;
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_GATE  = 8'h04;
  localparam logic [7:0] ADR_UPLEN = 8'h08;
  localparam logic [7:0] ADR_FPOS  = 8'h0c;
  localparam logic [7:0] ADR_UPWR  = 8'h10;
  localparam logic [7:0] ADR_STAT  = 8'h14;
  localparam logic [7:0] ADR_ONES  = 8'h18;
  localparam logic [7:0] ADR_ZERO  = 8'h1c;
  localparam logic [7:0] ADR_TOTAL = 8'h20;
  localparam logic [7:0] ADR_BITS  = 8'h24;
  localparam logic [7:0] ADR_RATE  = 8'h28;
  localparam logic [7:0] ADR_TIME  = 8'h2c;
  localparam logic [7:0] ADR_PROG  = 8'h30;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] GATE_RST  = 32'h0000_0001;
  localparam logic [31:0] UPLEN_RST = 32'h0000_0080;
  localparam logic [31:0] FPOS_RST  = 32'h0000_0001;
  typedef enum logic [2:0] {
    BED_PRBS7 = 3'h0, BED_PRBS9 = 3'h1, BED_PRBS15 = 3'h2,
    BED_PRBS23 = 3'h3, BED_PRBS31 = 3'h4, BED_USER = 3'h5
  } bed_pat_t;
  typedef enum logic [1:0] {
    BED_REPEAT = 2'h0, BED_SINGLE = 2'h1, BED_UNTIMED = 2'h2
  } bed_gate_t;
  typedef enum logic [1:0] {
    BED_DIFF = 2'h0, BED_TRUE = 2'h1, BED_COMP = 2'h2
  } bed_in_t;
  typedef enum logic [1:0] {
    BED_ELAPSED = 2'h0, BED_REMAIN = 2'h1, BED_START = 2'h2
  } bed_time_t;
  typedef enum logic [3:0] {
    BED_IDLE = 4'b0001, BED_HUNT = 4'b0010, BED_FRAME = 4'b0100,
    BED_LOCK = 4'b1000
  } bed_st_t;
  // ctrl word layout, high bit first
  typedef struct packed {
    logic [9:0] spare;
    logic       hist_clr;
    logic       current;
    logic [1:0] view;
    logic [1:0] time_view;
    bed_gate_t  gating;
    logic       tracking;
    logic       frame_sync;
    logic [3:0] thr_dec;
    logic       auto_sync;
    bed_in_t    input_sel;
    logic       polarity_select;
    bed_pat_t   pattern;
    logic       start;
  } bed_ctrl_t;
  typedef struct packed {
    logic     valid;
    logic     data_p;
    logic     data_n;
  } bed_rx_t;
  typedef struct packed {
    bed_pat_t pattern;
    logic     polarity_select;
  } bed_trk_t;
endpackage

// [src/bed_upat_mem.sv]
// bed_upat_mem: user pattern store, one bit per word, registered read.
// assumes writes from the apb side and reads from the reference walker.
`timescale 1ns/1ps
module bed_upat_mem (
  // clock
  input  wire logic                      pclk,
  // write side
  input  wire logic                      we,
  input  wire logic [bed_pkg::UPAT_AW-1:0] waddr,
  input  wire logic                      wdata,
  // read side
  input  wire logic [bed_pkg::UPAT_AW-1:0] raddr,
  output logic                           rdata
);
  import bed_pkg::*;
  logic mem [UPAT_DEPTH];
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule

// [src/bed_prbs.sv]
// bed_prbs: self-seeding prbs reference, one step per bit strobe.
// assumes load presents received bits while hunting for lock.
`timescale 1ns/1ps
module bed_prbs (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // control
  input  wire bed_pkg::bed_pat_t pattern,
  input  wire logic              step,
  input  wire logic              load,
  input  wire logic              load_bit,
  // reference
  output logic                   ref_bit
);
  import bed_pkg::*;
  logic [30:0] state;
  logic        fb;
  always_comb begin
    unique case (pattern)
      BED_PRBS7:  fb = state[6] ^ state[5];
      BED_PRBS9:  fb = state[8] ^ state[4];
      BED_PRBS15: fb = state[14] ^ state[13];
      BED_PRBS23: fb = state[22] ^ state[17];
      default:    fb = state[30] ^ state[27];
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= 31'h7fff_ffff;
    end else if (step) begin
      state <= {state[29:0], load ? load_bit : fb};
    end
  end
  assign ref_bit = fb;
endmodule

// [src/bed_checker.sv]
// bed_checker: bit error detector with apb registers.
// assumes rx bits arrive as single-cycle strobes synchronous to pclk.
// What this block does
// - count received one where zero expected
// - count received zero where one expected
// - total equals both error counts summed
// - warn on no input, sync loss, error
// - sticky history when a warning clears
// - progress percent of measurement period
// - bit rate follows received stream strobe
// - auto resync switchable, decade threshold
// - repeat, single, untimed gating, 1s to 9d23:59:59
// - report elapsed, remaining or start time
// - frame position 1 to length minus 64
// - frame sync switchable for user pattern
// - prbs 7,9,15,23,31 or user pattern
// - negative logic inverts received level
// - input from pair, true or complement
// - result views: all, split, total, zoom
// - tracking copies companion pattern settings
// - current on updates live, else end
// - match 64 frame bits then compare
// - resync when rate exceeds threshold
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module bed_checker (
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // received stream and companion source
  input  wire bed_pkg::bed_rx_t  rx,
  input  wire bed_pkg::bed_trk_t trk,
  // alarms
  output logic                   warn_no_data,
  output logic                   warn_sync_loss,
  output logic                   warn_error,
  output logic                   history
);
  import bed_pkg::*;
  bed_ctrl_t   ctrl;
  logic [31:0] gate_s, uplen, fpos;
  logic [31:0] ones_c, zero_c, bits_c, ones_l, zero_l, bits_l;
  logic [31:0] sec_c, start_s, epoch_s;
  logic [25:0] tick_c;
  logic [IDLE_LOG-1:0] idle_c;
  logic [SYNC_WIN_LOG:0] win_bits, win_err;
  logic [UPAT_AW-1:0]    uptr, up_waddr;
  logic [6:0]  frame_c;
  logic        running, wr, rd, up_we, up_bit, pr_ref, step, rx_bit;
  logic        ref_bit, err1, err0, thr_hit, meas_end, bad_addr;
  logic        any_warn, any_warn_q;
  bed_pat_t    pat;
  logic        pol;
  bed_st_t     st;
  logic [31:0] total_c, rate, prog, tval, next_rd;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pat = ctrl.tracking ? trk.pattern : ctrl.pattern;
  assign pol = ctrl.tracking ? trk.polarity_select : ctrl.polarity_select;
  assign step = rx.valid;

  always_comb begin
    unique case (ctrl.input_sel)
      BED_TRUE: rx_bit = rx.data_p;
      BED_COMP: rx_bit = !rx.data_n;
      default:  rx_bit = rx.data_p & !rx.data_n;
    endcase
    rx_bit = rx_bit ^ pol;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= bed_ctrl_t'(CTRL_RST);
      gate_s <= GATE_RST;
      uplen  <= UPLEN_RST;
      fpos   <= FPOS_RST;
    end else begin
      ctrl.hist_clr <= 1'b0;
      if (wr && paddr == ADR_CTRL) begin
        ctrl <= bed_ctrl_t'(pwdata);
      end
      if (wr && paddr == ADR_GATE && pwdata >= GATE_MIN_S
          && pwdata <= GATE_MAX_S) begin
        gate_s <= pwdata;
      end
      if (wr && paddr == ADR_UPLEN && pwdata != 32'h0
          && pwdata <= 32'(UPAT_DEPTH)) begin
        uplen <= pwdata;
      end
      if (wr && paddr == ADR_FPOS && pwdata >= 32'h1
          && pwdata <= uplen - 32'(FRAME_BITS)) begin
        fpos <= pwdata;
      end
    end
  end
  assign up_we    = wr && paddr == ADR_UPWR;
  assign up_waddr = pwdata[UPAT_AW+7:8];

  bed_upat_mem i_bed_upat_mem (
    .pclk  (pclk),
    .we    (up_we),
    .waddr (up_waddr),
    .wdata (pwdata[0]),
    .raddr (uptr),
    .rdata (up_bit)
  );
  bed_prbs i_bed_prbs (
    .pclk     (pclk),
    .presetn  (presetn),
    .pattern  (pat),
    .step     (step),
    .load     (st != BED_LOCK),
    .load_bit (rx_bit),
    .ref_bit  (pr_ref)
  );

  assign ref_bit = (pat == BED_USER) ? up_bit : pr_ref;
  assign err1 = step && st == BED_LOCK && rx_bit && !ref_bit;
  assign err0 = step && st == BED_LOCK && !rx_bit && ref_bit;
  assign thr_hit = ctrl.auto_sync && win_bits[SYNC_WIN_LOG]
    && ((64'(win_err) << (6'(ctrl.thr_dec) * 6'h3))
        > 64'(1 << SYNC_WIN_LOG));

  // user pointer wraps at pattern length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uptr <= '0;
    end else if (st == BED_IDLE) begin
      uptr <= UPAT_AW'(fpos - 32'h1);
    end else if (step && (st != BED_FRAME || rx_bit == up_bit)) begin
      uptr <= (32'(uptr) + 32'h1 >= uplen) ? '0 : uptr + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= BED_IDLE;
      frame_c <= '0;
    end else if (!running) begin
      st <= BED_IDLE;
    end else begin
      unique case (st)
        BED_IDLE: begin
          frame_c <= '0;
          st <= (pat == BED_USER && ctrl.frame_sync
                 && uplen >= 32'(FRAME_MIN_LEN)) ? BED_FRAME : BED_HUNT;
        end
        BED_FRAME: if (step) begin
          if (rx_bit != up_bit) begin
            frame_c <= '0;
            st <= BED_IDLE;
          end else if (frame_c == 7'(FRAME_BITS - 1)) begin
            st <= BED_LOCK;
          end else begin
            frame_c <= frame_c + 7'h1;
          end
        end
        BED_HUNT: if (step) begin
          frame_c <= frame_c + 7'h1;
          if (frame_c == 7'(FRAME_BITS - 1)) begin
            st <= BED_LOCK;
          end
        end
        BED_LOCK: if (thr_hit) begin
          st <= BED_IDLE;
        end
      endcase
    end
  end

  // sync window error tally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_bits <= '0;
      win_err  <= '0;
    end else if (st != BED_LOCK || win_bits[SYNC_WIN_LOG]) begin
      win_bits <= '0;
      win_err  <= '0;
    end else if (step) begin
      win_bits <= win_bits + 1'b1;
      win_err  <= win_err + (err1 || err0);
    end
  end

  assign meas_end = ctrl.gating != BED_UNTIMED && running
    && sec_c + 32'h1 >= gate_s && tick_c == 26'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      tick_c  <= '0;
      sec_c   <= '0;
      start_s <= '0;
      epoch_s <= '0;
    end else begin
      if (tick_c == 26'(TICK_CYCLES - 1)) begin
        tick_c  <= '0;
        epoch_s <= epoch_s + 32'h1;
        if (running) begin
          sec_c <= sec_c + 32'h1;
        end
      end else begin
        tick_c <= tick_c + 26'h1;
      end
      if (ctrl.start && !running) begin
        running <= 1'b1;
        sec_c   <= '0;
        start_s <= epoch_s;
      end else if (!ctrl.start) begin
        running <= 1'b0;
      end else if (running && ctrl.gating != BED_UNTIMED
                   && sec_c >= gate_s) begin
        sec_c   <= '0;
        running <= ctrl.gating == BED_REPEAT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_c <= '0;
      zero_c <= '0;
      bits_c <= '0;
    end else if (ctrl.start && !running || running && sec_c >= gate_s
                 && ctrl.gating != BED_UNTIMED) begin
      ones_c <= '0;
      zero_c <= '0;
      bits_c <= '0;
    end else if (running && st == BED_LOCK && step) begin
      ones_c <= ones_c + {31'h0, err1};
      zero_c <= zero_c + {31'h0, err0};
      bits_c <= bits_c + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_l <= '0;
      zero_l <= '0;
      bits_l <= '0;
    end else if (ctrl.current || (running && sec_c >= gate_s
                 && ctrl.gating != BED_UNTIMED)) begin
      ones_l <= ones_c;
      zero_l <= zero_c;
      bits_l <= bits_c;
    end
  end
  assign total_c = ones_l + zero_l;
  assign rate = (bits_l == '0) ? '0
    : 32'((64'(total_c) << 20) / 64'(bits_l));
  assign prog = (ctrl.gating == BED_UNTIMED || gate_s == '0) ? '0
    : 32'((64'(sec_c) * 64'd100) / 64'(gate_s));
  always_comb begin
    unique case (ctrl.time_view)
      BED_REMAIN: tval = gate_s - sec_c;
      BED_START:  tval = start_s;
      default:    tval = sec_c;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_c         <= '0;
      warn_no_data   <= 1'b0;
      warn_sync_loss <= 1'b0;
      warn_error     <= 1'b0;
      any_warn_q     <= 1'b0;
      history        <= 1'b0;
    end else begin
      idle_c         <= step ? '0 : (&idle_c ? idle_c : idle_c + 1'b1);
      warn_no_data   <= running && &idle_c;
      warn_sync_loss <= running && st != BED_LOCK;
      warn_error     <= err1 || err0;
      any_warn_q     <= any_warn;
      if (any_warn_q && !any_warn) begin
        history <= 1'b1;
      end else if (ctrl.hist_clr) begin
        history <= 1'b0;
      end
    end
  end
  assign any_warn = warn_no_data || warn_sync_loss || warn_error;

  assign bad_addr = paddr[1:0] != 2'h0 || paddr > ADR_PROG;
  always_comb begin
    next_rd = '0;
    unique case (paddr)
      ADR_CTRL:  next_rd = ctrl;
      ADR_GATE:  next_rd = gate_s;
      ADR_UPLEN: next_rd = uplen;
      ADR_FPOS:  next_rd = fpos;
      ADR_STAT:  next_rd = {24'h0, st, history, warn_error,
                            warn_sync_loss, warn_no_data};
      ADR_ONES:  next_rd = (ctrl.view == 2'h2) ? '0 : ones_l;
      ADR_ZERO:  next_rd = (ctrl.view == 2'h2) ? '0 : zero_l;
      ADR_TOTAL: next_rd = (ctrl.view == 2'h1) ? '0 : total_c;
      ADR_BITS:  next_rd = (ctrl.view == 2'h0) ? bits_l : '0;
      ADR_RATE:  next_rd = rate;
      ADR_TIME:  next_rd = tval;
      ADR_PROG:  next_rd = prog;
      default:   next_rd = '0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd) begin
      prdata  <= next_rd;
      pslverr <= bad_addr;
    end
  end

  chk_err_one_counts: assert property (@(posedge pclk) disable iff (!presetn)
    err1 && running && !(ctrl.start && !running) && ones_c != '1
    && !(sec_c >= gate_s && ctrl.gating != BED_UNTIMED)
    |=> ones_c == $past(ones_c) + 32'h1)
    else $error("false one not counted");
  chk_err_zero_counts: assert property (@(posedge pclk) disable iff (!presetn)
    err0 && running && !(sec_c >= gate_s && ctrl.gating != BED_UNTIMED)
    |=> zero_c == $past(zero_c) + 32'h1)
    else $error("false zero not counted");
  chk_total_sum: assert property (@(posedge pclk) disable iff (!presetn)
    total_c == ones_l + zero_l)
    else $error("total mismatch");
  chk_sync_warn: assert property (@(posedge pclk) disable iff (!presetn)
    running && st != BED_LOCK |=> warn_sync_loss)
    else $error("sync loss not flagged");
  chk_history_set: assert property (@(posedge pclk) disable iff (!presetn)
    any_warn_q && !any_warn |=> history)
    else $error("history not set");
  chk_no_err_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
    st != BED_LOCK |-> !err1 && !err0)
    else $error("error outside lock");
  chk_resync_drop: assert property (@(posedge pclk) disable iff (!presetn)
    st == BED_LOCK && thr_hit && running |=> st == BED_IDLE)
    else $error("resync not taken");
  chk_frame_len: assert property (@(posedge pclk) disable iff (!presetn)
    st == BED_FRAME |-> uplen >= 32'(FRAME_MIN_LEN))
    else $error("frame sync on short pattern");
  cov_lock: cover property (@(posedge pclk) st == BED_LOCK);
  cov_err: cover property (@(posedge pclk) err1 ##1 err0);
  cov_hist: cover property (@(posedge pclk) $rose(history));
  cov_period: cover property (@(posedge pclk) meas_end);
endmodule

// [tb/bed_src.sv]
// bed_src: stream model of the device under test feeding the checker.
// assumes the pclk domain; one bit strobe every four cycles when sending.
`timescale 1ns/1ps
module bed_src (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // stream control
  input  wire logic        en,
  input  wire logic        lvl,
  input  wire logic        skew,
  // line
  output bed_pkg::bed_rx_t rx
);
  import bed_pkg::*;
  logic [1:0] div;
  logic       junk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div  <= 2'h0;
      junk <= 1'b0;
    end else begin
      div  <= div + 2'h1;
      junk <= ~junk;
    end
  end
  // skew breaks the complement line; idle lines toggle every cycle
  always_comb begin
    rx.valid  = en && (div == 2'h0);
    rx.data_p = en ? lvl : junk;
    rx.data_n = en ? (skew ? lvl : ~lvl) : ~junk;
  end
endmodule

// [tb/bed_checker_bench.sv]
// bed_checker_bench: apb-driven tests of the error checker.
// assumes bed_src supplies the received stream at one bit per 4 cycles.
`timescale 1ns/1ps
module bed_checker_bench;
  import bed_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  bed_rx_t     rx;
  bed_trk_t    trk;
  logic        warn_no_data;
  logic        warn_sync_loss;
  logic        warn_error;
  logic        history;
  logic        en;
  logic        lvl;
  logic        skew;
  bed_ctrl_t   ctl;
  logic [31:0] ones;
  logic [31:0] zeros;
  logic [31:0] total;
  logic [31:0] bits;
  logic [31:0] rate;
  logic [31:0] rq;
  logic        re;
  int          failures;
  int          checked;
  int          cycles;

  bed_checker i_bed_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx(rx), .trk(trk),
    .warn_no_data(warn_no_data), .warn_sync_loss(warn_sync_loss),
    .warn_error(warn_error), .history(history)
  );
  bed_src i_bed_src (
    .pclk(pclk), .presetn(presetn), .en(en), .lvl(lvl), .skew(skew),
    .rx(rx)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      final_report();
    end
  end

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    rd(a, q);
    cmp_val(q, x);
  endtask

  task automatic upat(input logic b);
    wr(ADR_UPLEN, 32'h80);
    for (int i = 0; i < 128; i++) begin
      wr(ADR_UPWR, {12'h0, 12'(i), 7'h0, b});
    end
  endtask
  // restart a measurement and send 160 bits of a constant level
  task automatic start(input logic l, input logic s);
    ctl.start = 1'b0;
    wr(ADR_CTRL, ctl);
    ctl.start = 1'b1;
    wr(ADR_CTRL, ctl);
    en   <= 1'b1;
    lvl  <= l;
    skew <= s;
    repeat (640) @(posedge pclk);
  endtask
  task automatic snap(input logic eo, input logic ez);
    en <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ADR_ONES, ones);
    rd(ADR_ZERO, zeros);
    rd(ADR_TOTAL, total);
    rd(ADR_BITS, bits);
    rd(ADR_RATE, rate);
    cmp_bit(ones != 32'h0, eo);
    cmp_bit(zeros != 32'h0, ez);
    cmp_val(total, ones + zeros);
    cmp_bit(bits != 32'h0, 1'b1);
    cmp_val(rate, bits == 32'h0 ? 32'h0 : 32'((64'(total) << 20) / bits));
  endtask
  function automatic logic flg(input int w);
    case (w)
      0: return warn_no_data;
      1: return warn_sync_loss;
      2: return warn_error;
      default: return history;
    endcase
  endfunction
  task automatic poll(input int w, input logic v);
    int n;
    n = 0;
    while (flg(w) !== v && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    cmp_bit(flg(w), v);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    trk = '0;
    en = 1'b0;
    lvl = 1'b0;
    skew = 1'b0;
    ctl = '0;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_bit(warn_no_data | warn_sync_loss | warn_error | history, 1'b0);
    rdchk(ADR_CTRL, CTRL_RST);
    rdchk(ADR_GATE, GATE_RST);
    rdchk(ADR_UPLEN, UPLEN_RST);
    rdchk(ADR_FPOS, FPOS_RST);
    apb(1'b0, 8'h34, 32'h0, rq, re);
    cmp_val(rq, 32'h0);
    cmp_bit(re, 1'b1);
    $display("test reset done");
    wr(ADR_GATE, 32'h0);
    rdchk(ADR_GATE, GATE_MIN_S);
    wr(ADR_GATE, GATE_MAX_S);
    rdchk(ADR_GATE, GATE_MAX_S);
    wr(ADR_GATE, GATE_MAX_S + 32'h1);
    rdchk(ADR_GATE, GATE_MAX_S);
    wr(ADR_UPLEN, 32'h0);
    rdchk(ADR_UPLEN, UPLEN_RST);
    wr(ADR_FPOS, 32'h41);
    rdchk(ADR_FPOS, FPOS_RST);
    wr(ADR_FPOS, 32'h40);
    rdchk(ADR_FPOS, 32'h40);
    wr(ADR_FPOS, 32'h0);
    rdchk(ADR_FPOS, 32'h40);
    $display("test limits done");
    ctl.pattern = BED_USER;
    ctl.gating = BED_UNTIMED;
    ctl.current = 1'b1;
    ctl.input_sel = BED_TRUE;
    ctl.thr_dec = 4'h8;
    upat(1'b1);
    start(1'b0, 1'b0);
    poll(2, 1'b1);
    snap(1'b0, 1'b1);
    start(1'b1, 1'b0);
    poll(2, 1'b0);
    cmp_bit(history, 1'b1);
    ctl.hist_clr = 1'b1;
    wr(ADR_CTRL, ctl);
    ctl.hist_clr = 1'b0;
    wr(ADR_CTRL, ctl);
    poll(3, 1'b0);
    snap(1'b0, 1'b0);
    poll(0, 1'b1);
    $display("test alarms done");
    ctl.polarity_select = 1'b1;
    start(1'b1, 1'b0);
    snap(1'b0, 1'b1);
    start(1'b0, 1'b0);
    snap(1'b0, 1'b0);
    ctl.polarity_select = 1'b0;
    ctl.input_sel = BED_COMP;
    start(1'b1, 1'b1);
    snap(1'b0, 1'b1);
    ctl.input_sel = BED_TRUE;
    start(1'b1, 1'b1);
    snap(1'b0, 1'b0);
    ctl.input_sel = BED_DIFF;
    start(1'b1, 1'b0);
    snap(1'b0, 1'b0);
    $display("test input done");
    ctl.tracking = 1'b1;
    trk.pattern <= BED_USER;
    trk.polarity_select <= 1'b1;
    start(1'b1, 1'b0);
    snap(1'b0, 1'b1);
    ctl.tracking = 1'b0;
    ctl.auto_sync = 1'b1;
    ctl.thr_dec = 4'h2;
    start(1'b0, 1'b0);
    poll(1, 1'b1);
    ctl.auto_sync = 1'b0;
    $display("test tracking and resync done");
    upat(1'b0);
    start(1'b1, 1'b0);
    snap(1'b1, 1'b0);
    $display("test false one done");
    ctl.view = 2'h2;
    wr(ADR_CTRL, ctl);
    rdchk(ADR_ONES, 32'h0);
    ctl.view = 2'h1;
    ctl.time_view = BED_REMAIN;
    ctl.gating = BED_SINGLE;
    wr(ADR_CTRL, ctl);
    rdchk(ADR_TOTAL, 32'h0);
    rdchk(ADR_TIME, GATE_MAX_S);
    rdchk(ADR_PROG, 32'h0);
    $display("test views done");
    final_report();
  end
endmodule
